// file: hdl/pcx_port_ctrl.sv
// Low-port latches, drive modes, third routing register and pin drivers
//
// How it works
// - Pullup-disable bit turns off all weak pullups
// - Routing enable low forces all pins input
// - Second conversion start routed only when enabled
// - Timer trigger and count routed when enabled
// - Second serial tx and rx routed when enabled
// - Low-port off: port 0 top pins normal
// - Multiplexed: skip pins 7,6,5, strobes drive
// - Non-multiplexed: skip pins 7,6, strobes drive
// - First conversion start routed only when enabled
// - Latch 0 drives low, 1 per mode
// - Port read returns pin level
// - Latches reset to ones, byte and bit writable
// - Mode bit: 0 open-drain, 1 push-pull
// - Two-wire and mode-0 receive forced open-drain
// - Analog port 1 pin: no input, no pullup
// - Digital port 1 pin reads level, pullup global
// - Analog port 1 pins skipped by routing
// - Analog pins still drive from latch and mode
// - Non-multiplexed memory drives port 1 high address
// - Memory drives port 2 with address byte
// - Memory drives port 3 with data byte
// - Skipped pin passes signal to next free
// - Read-modify-write read returns latch contents
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ns
module pcx_port_ctrl #(
	parameter int ADDR_W = 8
) (
	input  wire logic              clk_sys,
	input  wire logic              rst_b,
	input  wire logic              ce,
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [7:0]        reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	input  wire logic              reg_bit_wr,
	input  wire logic [2:0]        reg_bit_idx,
	input  wire logic              reg_bit_val,
	input  wire logic              reg_rmw,
	output wire logic [7:0]        reg_rdata,
	input  wire logic              ext_mem_nonmux_select,
	input  wire logic              emif_active,
	input  wire logic              emif_wr_b,
	input  wire logic              emif_rd_b,
	input  wire logic              emif_ale,
	input  wire logic [15:0]       emif_addr,
	input  wire logic [7:0]        emif_data_out,
	input  wire logic              emif_data_oe,
	input  wire logic [31:0]       up_claim,
	input  wire logic [31:0]       up_drive_sel,
	input  wire logic [31:0]       up_drive_val,
	input  wire logic [31:0]       up_od,
	input  wire logic              second_serial_tx,
	input  wire logic              second_serial_mode0,
	input  wire logic              second_serial_rx_drive,
	output wire logic              second_serial_receive,
	output wire logic              timer_d_trigger_input,
	output wire logic              timer_d_count_input,
	output wire logic              conv_start_a_input,
	output wire logic              conv_start_b_input,
	output wire logic [31:0]       route_map,
	input  wire logic [31:0]       pin_in,
	output wire logic [31:0]       pin_out,
	output wire logic [31:0]       pin_oe,
	output wire logic [31:0]       pin_pullup_en
);
	localparam int NP = pcx_pkg::PCX_PINS;
	localparam int NS = pcx_pkg::PCX_SLOTS;

	logic [31:0] latch_r;
	logic [31:0] latch_nxt;
	logic [31:0] mode_r;
	logic [31:0] mode_nxt;
	logic [7:0]  xbar_r;
	logic [7:0]  xbar_nxt;
	logic [7:0]  ain_r;
	logic [7:0]  ain_nxt;
	logic [7:0]  rdata_r;
	logic [7:0]  rdata_nxt;

	wire logic [3:0]    hit_latch;
	wire logic [3:0]    hit_mode;
	wire logic          hit_xbar;
	wire logic          hit_ain;
	wire logic          wr_go;
	wire logic          bit_go;
	wire logic          rd_go;
	wire logic [31:0]   din;
	wire logic [31:0]   port_view;
	wire logic [3:0][7:0] rd_latch_sel;
	wire logic [3:0][7:0] rd_mode_sel;

	generate
		if (ADDR_W < 8) begin : g_chk
			$error("pcx_port_ctrl needs an address of at least 8 bits");
		end
	endgenerate

	// Address decode
	genvar gp;
	generate
		for (gp = 0; gp < 4; gp++) begin : g_dec
			assign hit_latch[gp] = reg_addr == ADDR_W'(pcx_pkg::PCX_OFS_LATCH[gp]);
			assign hit_mode[gp]  = reg_addr == ADDR_W'(pcx_pkg::PCX_OFS_MODE[gp]);
			// Read-modify-write reads the latch, otherwise the pins
			assign rd_latch_sel[gp] = hit_latch[gp] ? port_view[8*gp +: 8] : 8'h00;
			assign rd_mode_sel[gp]  = hit_mode[gp] ? mode_r[8*gp +: 8] : 8'h00;
		end
	endgenerate

	assign hit_xbar = reg_addr == ADDR_W'(pcx_pkg::PCX_OFS_XBAR3);
	assign hit_ain  = reg_addr == ADDR_W'(pcx_pkg::PCX_OFS_AIN1);
	assign wr_go    = ce & reg_wr;
	assign bit_go   = ce & reg_bit_wr;
	assign rd_go    = ce & reg_rd;

	assign port_view = reg_rmw ? latch_r : din;

	// Next register values: byte writes and bit writes on the port latches
	always_comb begin
		latch_nxt = latch_r;
		mode_nxt  = mode_r;
		for (int i = 0; i < 4; i++) begin
			if (wr_go && hit_latch[i]) begin
				latch_nxt[8*i +: 8] = reg_wdata;
			end
			if (bit_go && hit_latch[i]) begin
				latch_nxt[8*i + int'(reg_bit_idx)] = reg_bit_val;
			end
			if (wr_go && hit_mode[i]) begin
				mode_nxt[8*i +: 8] = reg_wdata;
			end
		end
	end

	assign xbar_nxt = (wr_go && hit_xbar) ? reg_wdata : xbar_r;
	assign ain_nxt  = (wr_go && hit_ain) ? reg_wdata : ain_r;

	// Read data stands only in the cycle after the strobe
	assign rdata_nxt = !rd_go ? 8'h00 :
		(rd_latch_sel[0] | rd_latch_sel[1] | rd_latch_sel[2] | rd_latch_sel[3] |
		 rd_mode_sel[0] | rd_mode_sel[1] | rd_mode_sel[2] | rd_mode_sel[3] |
		 (hit_xbar ? xbar_r : 8'h00) | (hit_ain ? ain_r : 8'h00));

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			latch_r <= {4{pcx_pkg::PCX_RST_LATCH}};
			mode_r  <= {4{pcx_pkg::PCX_RST_MODE}};
			xbar_r  <= pcx_pkg::PCX_RST_XBAR3;
			ain_r   <= pcx_pkg::PCX_RST_AIN1;
		end else if (ce) begin
			latch_r <= latch_nxt;
			mode_r  <= mode_nxt;
			xbar_r  <= xbar_nxt;
			ain_r   <= ain_nxt;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rdata_r <= 8'h00;
		end else if (ce) begin
			rdata_r <= rdata_nxt;
		end
	end

	assign reg_rdata = rdata_r;

	// Control bits
	wire logic pullup_global_disable;
	wire logic routing_enable;
	wire logic ext_mem_low_port_en;
	wire logic emif_low_live;

	assign pullup_global_disable = xbar_r[pcx_pkg::PCX_B_PULLUP_DIS];
	assign routing_enable        = xbar_r[pcx_pkg::PCX_B_ROUTE_EN];
	assign ext_mem_low_port_en   = xbar_r[pcx_pkg::PCX_B_LOW_PORT];
	assign emif_low_live         = ext_mem_low_port_en & emif_active;

	// Pins the allocator must pass over
	wire logic [31:0] skip;

	assign skip[4:0]   = 5'h00;
	assign skip[pcx_pkg::PCX_PIN_ALE] = ext_mem_low_port_en & ~ext_mem_nonmux_select;
	assign skip[pcx_pkg::PCX_PIN_RD]  = ext_mem_low_port_en;
	assign skip[pcx_pkg::PCX_PIN_WR]  = ext_mem_low_port_en;
	assign skip[15:8]  = ~ain_r;
	assign skip[31:16] = 16'h0000;

	// Enables of the routed signals, gated by the routing enable
	wire logic [NS-1:0] slot_en;

	assign slot_en[pcx_pkg::PCX_SLOT_TX]     = routing_enable & xbar_r[pcx_pkg::PCX_B_SERIAL];
	assign slot_en[pcx_pkg::PCX_SLOT_RX]     = routing_enable & xbar_r[pcx_pkg::PCX_B_SERIAL];
	assign slot_en[pcx_pkg::PCX_SLOT_TRIG]   = routing_enable & xbar_r[pcx_pkg::PCX_B_TRIG];
	assign slot_en[pcx_pkg::PCX_SLOT_COUNT]  = routing_enable & xbar_r[pcx_pkg::PCX_B_COUNT];
	assign slot_en[pcx_pkg::PCX_SLOT_CONV_A] = routing_enable & xbar_r[pcx_pkg::PCX_B_CONV_A];
	assign slot_en[pcx_pkg::PCX_SLOT_CONV_B] = routing_enable & xbar_r[pcx_pkg::PCX_B_CONV_B];

	// Chain of pickers: each signal takes the next pin not skipped or claimed
	wire logic [NS:0][NP-1:0] free;
	wire logic [NS-1:0][NP-1:0] pick;

	assign free[0] = ~(skip | up_claim);

	genvar gs;
	generate
		for (gs = 0; gs < NS; gs++) begin : g_slot
			pcx_pick #(
				.W (NP)
			) u_pick (
				.free      (free[gs]),
				.en        (slot_en[gs]),
				.pick      (pick[gs]),
				.free_left (free[gs+1])
			);
		end
	endgenerate

	assign route_map = ~free[NS] & ~up_claim & ~skip;

	// Routed inputs idle high when no pin carries them
	function automatic logic route_in(input logic [31:0] p, input logic [31:0] lvl);
		route_in = (|(p & lvl)) | ~(|p);
	endfunction

	assign second_serial_receive = route_in(pick[pcx_pkg::PCX_SLOT_RX], din);
	assign timer_d_trigger_input = route_in(pick[pcx_pkg::PCX_SLOT_TRIG], din);
	assign timer_d_count_input   = route_in(pick[pcx_pkg::PCX_SLOT_COUNT], din);
	assign conv_start_a_input    = route_in(pick[pcx_pkg::PCX_SLOT_CONV_A], din);
	assign conv_start_b_input    = route_in(pick[pcx_pkg::PCX_SLOT_CONV_B], din);

	// Peripheral drive per pin
	wire logic [31:0] rx_drv;
	wire logic [31:0] periph_sel;
	wire logic [31:0] periph_val;
	wire logic [31:0] periph_od;

	assign rx_drv     = second_serial_mode0 ? pick[pcx_pkg::PCX_SLOT_RX] : 32'h0000_0000;
	assign periph_sel = up_drive_sel | pick[pcx_pkg::PCX_SLOT_TX] | rx_drv;
	assign periph_val = (up_drive_sel & up_drive_val) |
		(pick[pcx_pkg::PCX_SLOT_TX] & {32{second_serial_tx}}) |
		(rx_drv & {32{second_serial_rx_drive}});
	assign periph_od  = up_od | rx_drv;

	// Memory interface drive per pin
	wire logic [31:0] emif_sel;
	wire logic [31:0] emif_val;

	assign emif_sel[4:0] = 5'h00;
	assign emif_val[4:0] = 5'h00;
	// Strobes combine with the latch so a cleared latch bit still holds low
	assign emif_sel[pcx_pkg::PCX_PIN_ALE] = skip[pcx_pkg::PCX_PIN_ALE];
	assign emif_val[pcx_pkg::PCX_PIN_ALE] = latch_r[pcx_pkg::PCX_PIN_ALE] & ~emif_ale;
	assign emif_sel[pcx_pkg::PCX_PIN_RD]  = skip[pcx_pkg::PCX_PIN_RD];
	assign emif_val[pcx_pkg::PCX_PIN_RD]  = latch_r[pcx_pkg::PCX_PIN_RD] & emif_rd_b;
	assign emif_sel[pcx_pkg::PCX_PIN_WR]  = skip[pcx_pkg::PCX_PIN_WR];
	assign emif_val[pcx_pkg::PCX_PIN_WR]  = latch_r[pcx_pkg::PCX_PIN_WR] & emif_wr_b;
	assign emif_sel[15:8]  = {8{emif_low_live & ext_mem_nonmux_select}};
	assign emif_val[15:8]  = emif_addr[15:8];
	assign emif_sel[23:16] = {8{emif_low_live}};
	assign emif_val[23:16] = ext_mem_nonmux_select ? emif_addr[7:0] : emif_addr[15:8];
	assign emif_sel[31:24] = {8{emif_low_live & emif_data_oe}};
	assign emif_val[31:24] = emif_data_out;

	// Port 1 digital input enable; other ports always digital
	wire logic [31:0] digital_en;

	assign digital_en = {16'hFFFF, ain_r, 8'hFF};

	genvar gn;
	generate
		for (gn = 0; gn < NP; gn++) begin : g_pin
			pcx_pin_cell u_cell (
				.route_en   (routing_enable),
				.latch      (latch_r[gn]),
				.push_pull  (mode_r[gn]),
				.periph_sel (periph_sel[gn]),
				.periph_val (periph_val[gn]),
				.periph_od  (periph_od[gn]),
				.emif_sel   (emif_sel[gn]),
				.emif_val   (emif_val[gn]),
				.digital_en (digital_en[gn]),
				.pullup_dis (pullup_global_disable),
				.pin_in     (pin_in[gn]),
				.pin_out    (pin_out[gn]),
				.pin_oe     (pin_oe[gn]),
				.pullup_en  (pin_pullup_en[gn]),
				.din        (din[gn])
			);
		end
	endgenerate
endmodule

// file: hdl/pcx_pkg.sv
// Shared offsets, reset values and field positions for the low-port I/O block
package pcx_pkg;
	// Register offsets, one per port, port 3 at the top
	localparam logic [3:0][7:0] PCX_OFS_LATCH = {8'hB0, 8'hA0, 8'h90, 8'h80};
	localparam logic [3:0][7:0] PCX_OFS_MODE  = {8'hA7, 8'hA6, 8'hA5, 8'hA4};
	localparam logic [7:0]      PCX_OFS_XBAR3 = 8'hE3;
	localparam logic [7:0]      PCX_OFS_AIN1  = 8'hAD;

	// Reset values
	localparam logic [7:0] PCX_RST_LATCH = 8'hFF;
	localparam logic [7:0] PCX_RST_MODE  = 8'h00;
	localparam logic [7:0] PCX_RST_XBAR3 = 8'h00;
	localparam logic [7:0] PCX_RST_AIN1  = 8'hFF;

	// Field positions in the third routing register
	localparam int PCX_B_PULLUP_DIS = 7;
	localparam int PCX_B_ROUTE_EN   = 6;
	localparam int PCX_B_CONV_B     = 5;
	localparam int PCX_B_TRIG       = 4;
	localparam int PCX_B_COUNT      = 3;
	localparam int PCX_B_SERIAL     = 2;
	localparam int PCX_B_LOW_PORT   = 1;
	localparam int PCX_B_CONV_A     = 0;

	// Port 0 pins used by the memory interface strobes
	localparam int PCX_PIN_WR  = 7;
	localparam int PCX_PIN_RD  = 6;
	localparam int PCX_PIN_ALE = 5;

	// Allocation slots of this register, in priority order
	localparam int PCX_SLOT_TX     = 0;
	localparam int PCX_SLOT_RX     = 1;
	localparam int PCX_SLOT_TRIG   = 2;
	localparam int PCX_SLOT_COUNT  = 3;
	localparam int PCX_SLOT_CONV_A = 4;
	localparam int PCX_SLOT_CONV_B = 5;
	localparam int PCX_SLOTS       = 6;

	localparam int PCX_PINS = 32;
endpackage

// file: hdl/pcx_pick.sv
// Picks the lowest free pin for one routed signal
`timescale 1ns/1ns
module pcx_pick #(
	parameter int W = 32
) (
	input  wire logic [W-1:0] free,
	input  wire logic         en,
	output wire logic [W-1:0] pick,
	output wire logic [W-1:0] free_left
);
	wire logic [W-1:0] lowest;

	generate
		if (W < 2) begin : g_chk
			$error("pcx_pick needs at least two pins");
		end
	endgenerate

	// Lowest set bit of the free mask
	assign lowest    = free & (~free + {{(W-1){1'b0}}, 1'b1});
	assign pick      = en ? lowest : {W{1'b0}};
	assign free_left = free & ~pick;
endmodule

// file: hdl/pcx_pin_cell.sv
// Output driver, pullup and input path of one port pin
`timescale 1ns/1ns
module pcx_pin_cell (
	input  wire logic route_en,
	input  wire logic latch,
	input  wire logic push_pull,
	input  wire logic periph_sel,
	input  wire logic periph_val,
	input  wire logic periph_od,
	input  wire logic emif_sel,
	input  wire logic emif_val,
	input  wire logic digital_en,
	input  wire logic pullup_dis,
	input  wire logic pin_in,
	output wire logic pin_out,
	output wire logic pin_oe,
	output wire logic pullup_en,
	output wire logic din
);
	wire logic val;
	wire logic drive_hi;

	// Memory interface, then routed peripheral, then the latch
	assign val      = emif_sel ? emif_val : (periph_sel ? periph_val : latch);
	// Forced open-drain signals never drive high
	assign drive_hi = push_pull & ~(periph_sel & periph_od & ~emif_sel);
	// Low drives, high drives only in push-pull; all inputs while routing is off
	assign pin_oe   = route_en & (~val | drive_hi);
	assign pin_out  = val;
	// Pullup off globally, in analog mode, or while driving low
	assign pullup_en = ~pullup_dis & digital_en & ~(pin_oe & ~val);
	// Analog pins read as zero
	assign din      = digital_en & pin_in;
endmodule

// file: test/pcx_port_ctrl_asserts.sv
// Checker for the low-port I/O block, bound to its top module
`timescale 1ns/1ns
module pcx_port_ctrl_asserts #(
	parameter int ADDR_W = 8
) (
	input wire logic              clk_sys,
	input wire logic              rst_b,
	input wire logic              ce,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [7:0]        reg_wdata,
	input wire logic              reg_wr,
	input wire logic              reg_rd,
	input wire logic              reg_bit_wr,
	input wire logic [2:0]        reg_bit_idx,
	input wire logic              reg_bit_val,
	input wire logic              reg_rmw,
	input wire logic [7:0]        reg_rdata,
	input wire logic              ext_mem_nonmux_select,
	input wire logic              emif_active,
	input wire logic [31:0]       up_drive_sel,
	input wire logic [31:0]       up_od,
	input wire logic [31:0]       route_map,
	input wire logic [31:0]       pin_in,
	input wire logic [31:0]       pin_out,
	input wire logic [31:0]       pin_oe,
	input wire logic [31:0]       pin_pullup_en
);
	logic [7:0] xb_r, lat2_r, md2_r, ain_r;
	wire logic [7:0] a8       = reg_addr[7:0];
	wire logic       at_p2    = a8 == pcx_pkg::PCX_OFS_LATCH[2];
	wire logic [7:0] bmask    = 8'h01 << reg_bit_idx;
	wire logic [7:0] lat2_bit = (lat2_r & ~bmask) | ({8{reg_bit_val}} & bmask);
	wire logic [7:0] xb_nxt   = (reg_wr && a8 == pcx_pkg::PCX_OFS_XBAR3) ? reg_wdata : xb_r;
	wire logic [7:0] md2_nxt  = (reg_wr && a8 == pcx_pkg::PCX_OFS_MODE[2]) ? reg_wdata : md2_r;
	wire logic [7:0] ain_nxt  = (reg_wr && a8 == pcx_pkg::PCX_OFS_AIN1) ? reg_wdata : ain_r;
	wire logic [7:0] lat2_nxt = (reg_wr && at_p2) ? reg_wdata : (reg_bit_wr && at_p2) ? lat2_bit : lat2_r;
	wire logic       p2_quiet = xb_r[6] && !emif_active && up_drive_sel[23:16] == 8'h00
		&& up_od[23:16] == 8'h00 && route_map[23:16] == 8'h00;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			xb_r   <= pcx_pkg::PCX_RST_XBAR3;
			lat2_r <= pcx_pkg::PCX_RST_LATCH;
			md2_r  <= pcx_pkg::PCX_RST_MODE;
			ain_r  <= pcx_pkg::PCX_RST_AIN1;
		end else if (ce) begin
			xb_r   <= xb_nxt;
			lat2_r <= lat2_nxt;
			md2_r  <= md2_nxt;
			ain_r  <= ain_nxt;
		end
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	AST_RD_IDLE: assert property (!$past(reg_rd) && $past(ce) |-> reg_rdata == 8'h00)
		else $error("read data not zero outside read answer");
	AST_XBAR_OFF: assert property (!xb_r[6] |-> pin_oe == 32'h0000_0000)
		else $error("pin driven while routing disabled");
	AST_PU_OFF: assert property (xb_r[7] |-> pin_pullup_en == 32'h0000_0000)
		else $error("pullup on while globally disabled");
	AST_PU_ON: assert property (!xb_r[7] && !xb_r[6] |-> pin_pullup_en[7:0] == 8'hFF)
		else $error("pullup off while globally enabled");
	AST_P1_PULLUP: assert property ((pin_pullup_en[15:8] & ~ain_r) == 8'h00)
		else $error("pullup on for analog pin");
	AST_P2_DRIVE: assert property (p2_quiet |-> pin_oe[23:16] == (~lat2_r | md2_r)
		&& (pin_out[23:16] & pin_oe[23:16]) == (lat2_r & pin_oe[23:16]))
		else $error("port 2 drive not from latch and mode");
	AST_P2_READ: assert property (ce && reg_rd && at_p2 && !reg_rmw
		|=> reg_rdata == $past(pin_in[23:16]))
		else $error("port 2 read not pin level");
	AST_RMW_READ: assert property (ce && reg_rd && at_p2 && reg_rmw |=> reg_rdata == $past(lat2_r))
		else $error("modify read not latch value");
	AST_P1_READ: assert property (ce && reg_rd && a8 == pcx_pkg::PCX_OFS_LATCH[1] && !reg_rmw
		|=> reg_rdata == $past(pin_in[15:8] & ain_r))
		else $error("port 1 read ignores analog select");
	AST_SKIP: assert property (xb_r[6] && xb_r[1] |-> route_map[7:6] == 2'b00
		&& (ext_mem_nonmux_select || !route_map[5]))
		else $error("memory strobe pin given to routing");

	cover property (xb_r[6] && xb_r[1] && !ext_mem_nonmux_select && route_map != 32'h0);
	cover property (reg_rd && reg_rmw && at_p2);
	cover property (emif_active && xb_r[6]);
endmodule

bind pcx_port_ctrl pcx_port_ctrl_asserts #(.ADDR_W(ADDR_W)) u_pcx_port_ctrl_asserts (.clk_sys,
	.rst_b, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_bit_wr, .reg_bit_idx, .reg_bit_val,
	.reg_rmw, .reg_rdata, .ext_mem_nonmux_select, .emif_active, .up_drive_sel, .up_od, .route_map,
	.pin_in, .pin_out, .pin_oe, .pin_pullup_en);

// file: test/pcx_pins_model.sv
// Board model of the low-port pins: device drive, external drive, pullup, floating
`timescale 1ns/1ns
module pcx_pins_model (
	input  wire logic        clk_sys,
	input  wire logic [31:0] pin_out,
	input  wire logic [31:0] pin_oe,
	input  wire logic [31:0] pin_pullup_en,
	input  wire logic [31:0] ext_val,
	input  wire logic [31:0] ext_oe,
	output wire logic [31:0] pin_in
);
	logic [31:0] float_r;
	// An undriven pin without pullup wanders every cycle
	always_ff @(posedge clk_sys) begin
		float_r <= (float_r === 32'h0000_0000) ? 32'hFFFF_FFFF : 32'h0000_0000;
	end
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_oe & ext_val)
		| (~pin_oe & ~ext_oe & (pin_pullup_en | float_r));
endmodule

// file: test/pcx_port_ctrl_tb.sv
// Self-checking bench for the low-port I/O block
`timescale 1ns/1ns
module pcx_port_ctrl_tb;
	logic        clk_sys, rst_b, ce, reg_wr, reg_rd, reg_bit_wr, reg_bit_val, reg_rmw;
	logic [7:0]  reg_addr, reg_wdata, emif_data_out;
	logic [2:0]  reg_bit_idx;
	logic        ext_mem_nonmux_select, emif_active, emif_wr_b, emif_rd_b, emif_ale, emif_data_oe;
	logic [15:0] emif_addr;
	logic [31:0] up_claim, up_drive_sel, up_drive_val, up_od, ext_val, ext_oe;
	logic        second_serial_tx, second_serial_mode0, second_serial_rx_drive;
	wire logic [7:0]  reg_rdata;
	wire logic        second_serial_receive, timer_d_trigger_input, timer_d_count_input;
	wire logic        conv_start_a_input, conv_start_b_input;
	wire logic [31:0] route_map, pin_in, pin_out, pin_oe, pin_pullup_en;
	int          mismatches = 0;
	int          n_compared = 0;

	pcx_port_ctrl #(.ADDR_W(8)) u_pcx_port_ctrl (.clk_sys, .rst_b, .ce, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_bit_wr, .reg_bit_idx, .reg_bit_val, .reg_rmw, .reg_rdata,
		.ext_mem_nonmux_select, .emif_active, .emif_wr_b, .emif_rd_b, .emif_ale, .emif_addr,
		.emif_data_out, .emif_data_oe, .up_claim, .up_drive_sel, .up_drive_val, .up_od,
		.second_serial_tx, .second_serial_mode0, .second_serial_rx_drive, .second_serial_receive,
		.timer_d_trigger_input, .timer_d_count_input, .conv_start_a_input, .conv_start_b_input,
		.route_map, .pin_in, .pin_out, .pin_oe, .pin_pullup_en);
	pcx_pins_model u_pcx_pins_model (.clk_sys, .pin_out, .pin_oe, .pin_pullup_en, .ext_val,
		.ext_oe, .pin_in);

	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		#10;
	endtask
	task automatic bw(input logic [7:0] a, input logic [2:0] i, input logic v);
		@(posedge clk_sys);
		reg_bit_wr  <= 1'b1;
		reg_addr    <= a;
		reg_bit_idx <= i;
		reg_bit_val <= v;
		@(posedge clk_sys);
		reg_bit_wr <= 1'b0;
	endtask
	task automatic rdc(input string name, input logic [7:0] a, input logic m, input logic [7:0] e);
		@(posedge clk_sys);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		reg_rmw  <= m;
		@(posedge clk_sys);
		reg_rd  <= 1'b0;
		reg_rmw <= 1'b0;
		#10;
		chk(name, reg_rdata, e);
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	initial begin
		#200000;
		mismatches++;
		final_report();
	end

	initial begin
		{rst_b, reg_wr, reg_rd, reg_bit_wr, reg_bit_val, reg_rmw, reg_bit_idx} = '0;
		{reg_addr, reg_wdata, emif_data_out, emif_addr, emif_data_oe, emif_ale} = '0;
		{ext_mem_nonmux_select, emif_active, up_claim, up_drive_sel, up_drive_val, up_od} = '0;
		{ext_val, ext_oe, second_serial_tx, second_serial_mode0, second_serial_rx_drive} = '0;
		{ce, emif_wr_b, emif_rd_b} = 3'b111;
		repeat (2) @(posedge clk_sys);
		rst_b <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			rdc("latch", pcx_pkg::PCX_OFS_LATCH[i], 1'b1, 8'hFF);
			rdc("mode", pcx_pkg::PCX_OFS_MODE[i], 1'b0, 8'h00);
		end
		rdc("routing", 8'hE3, 1'b0, 8'h00);
		rdc("analog_sel", pcx_pkg::PCX_OFS_AIN1, 1'b0, 8'hFF);
		rdc("unmapped", 8'hF0, 1'b0, 8'h00);
		chk("oe_off", pin_oe, 32'h0);
		chk("pullup_on", pin_pullup_en, 32'hFFFF_FFFF);
		@(posedge clk_sys);
		ce <= 1'b0;
		wr(8'hE3, 8'h80);
		@(posedge clk_sys);
		ce <= 1'b1;
		rdc("frozen", 8'hE3, 1'b0, 8'h00);
		wr(8'hE3, 8'h80);
		chk("pullup_off", pin_pullup_en, 32'h0);
		$display("test reset and pullup done");

		wr(8'hE3, 8'h40);
		wr(8'hA0, 8'h0F);
		wr(8'hA6, 8'h33);
		chk("p2_oe", pin_oe[23:16], 8'hF3);
		chk("p2_out", pin_out[23:16] & pin_oe[23:16], 8'h03);
		bw(8'hA0, 3'd0, 1'b0);
		bw(8'hA6, 3'd7, 1'b1);
		rdc("p2_rmw", 8'hA0, 1'b1, 8'h0E);
		rdc("mode_bitwr", 8'hA6, 1'b0, 8'h33);
		ext_oe <= 32'h000C_0000;
		rdc("p2_pin", 8'hA0, 1'b0, 8'h02);
		$display("test drive modes done");

		wr(pcx_pkg::PCX_OFS_AIN1, 8'hE3);
		ext_oe  <= 32'h0000_FF00;
		ext_val <= 32'h0000_FF00;
		rdc("p1_pin", 8'h90, 1'b0, 8'hE3);
		chk("p1_pullup", pin_pullup_en[15:8], 8'hE3);
		ext_oe <= 32'h0;
		wr(8'h90, 8'h00);
		chk("p1_analog_oe", pin_oe[15:8], 8'hFF);
		wr(8'h90, 8'hFF);
		$display("test analog port done");

		up_claim <= 32'h1F;
		ext_oe   <= 32'h0000_0120;
		ext_val  <= 32'h0;
		wr(8'hE3, 8'h7F);
		chk("map_mux", route_map, 32'h0001_E300);
		ext_mem_nonmux_select <= 1'b1;
		wr(8'hE3, 8'h7F);
		chk("map_nonmux", route_map, 32'h0000_E320);
		chk("rx_in", second_serial_receive, 1'b0);
		wr(8'hE3, 8'h5B);
		chk("map_no_serial", route_map, 32'h0000_0320);
		chk("conv_b_idle", conv_start_b_input, 1'b1);
		chk("trig_in", timer_d_trigger_input, 1'b0);
		chk("count_in", timer_d_count_input, 1'b0);
		wr(8'hE3, 8'h5A);
		chk("map_no_conv_a", route_map, 32'h0000_0120);
		wr(8'hE3, 8'h42);
		chk("map_none", route_map, 32'h0);
		$display("test routing done");

		up_claim <= 32'h0;
		ext_oe   <= 32'h0;
		wr(8'hA4, 8'h01);
		up_drive_sel <= 32'h1;
		up_drive_val <= 32'h1;
		up_od        <= 32'h1;
		wr(8'hE3, 8'h40);
		chk("forced_od", pin_oe[0], 1'b0);
		up_od <= 32'h0;
		wr(8'hE3, 8'h40);
		chk("push_pull", pin_oe[0], 1'b1);
		$display("test open drain done");

		wr(pcx_pkg::PCX_OFS_AIN1, 8'hFF);
		for (int i = 1; i < 4; i++) begin
			wr(pcx_pkg::PCX_OFS_MODE[i], 8'hFF);
		end
		emif_active   <= 1'b1;
		emif_addr     <= 16'h5AC3;
		emif_data_out <= 8'h96;
		emif_data_oe  <= 1'b1;
		emif_wr_b     <= 1'b0;
		wr(8'hE3, 8'h42);
		chk("p1_addr", pin_out[15:8], 8'h5A);
		chk("p2_addr", pin_out[23:16], 8'hC3);
		chk("p3_data", pin_out[31:24], 8'h96);
		chk("wr_strobe", pin_out[7], 1'b0);
		ext_mem_nonmux_select <= 1'b0;
		wr(8'hE3, 8'h42);
		chk("p2_addr_mux", pin_out[23:16], 8'h5A);
		$display("test memory drive done");
		final_report();
	end
endmodule
